// >>> indicator_defines.vh
// constants for the indicator control block: register offsets, field
// positions, reset values, source codes and timing figures
// assumes a 16-bit management register file with five-bit register addresses
`ifndef INDICATOR_DEFINES_VH
`define INDICATOR_DEFINES_VH

// register addresses
`define ADDR_W               5
`define DATA_W               16
`define OFS_SOURCE_SELECT    5'h16
`define OFS_TIMING_SPEED     5'h18
`define OFS_OVERRIDE_POL     5'h19

// source select fields
`define SRC_ZERO_LSB         0
`define SRC_ONE_LSB          4
`define SRC_TWO_LSB          8
`define SRC_RSVD_LSB         12
`define SRC_RESET            16'h4A44

// timing and speed fields
`define TS_FIXED_BIT         15
`define TS_STRETCH_LSB       12
`define TS_FLASH_LSB         9
`define TS_QUAL_TWO_LSB      6
`define TS_QUAL_ONE_LSB      3
`define TS_QUAL_ZERO_LSB     0
`define TS_RESET             16'h4205
`define TS_WRITE_MASK        16'h7FFF

// override and polarity fields
`define OP_POL_TWO_BIT       14
`define OP_POL_ONE_BIT       13
`define OP_POL_ZERO_BIT      12
`define OP_OVR_TWO_LSB       4
`define OP_OVR_ONE_LSB       2
`define OP_OVR_ZERO_LSB      0
`define OP_RESET             16'h0000

// source codes
`define SRC_COLLISION        4'h0
`define SRC_ERROR            4'h1
`define SRC_DUPLEX           4'h2
`define SRC_DUPLEX_COL       4'h3
`define SRC_SPEED            4'h4
`define SRC_LINK             4'h5
`define SRC_TX               4'h6
`define SRC_RX               4'h7
`define SRC_ACTIVITY         4'h8
`define SRC_LINK_RX          4'h9
`define SRC_LINK_ACT         4'hA
`define SRC_ACT_FLASH        4'hB
`define SRC_TX_FLASH         4'hC
`define SRC_RX_FLASH         4'hD
`define SRC_INACTIVE         4'hF

// rate qualifier and override codes
`define QUAL_10BASE_T        3'h0
`define QUAL_100BASE_X       3'h5
`define OVR_NORMAL           2'h0
`define OVR_FLASH            2'h1
`define OVR_OFF              2'h2
`define OVR_ON               2'h3

// timing: a millisecond tick drives every stretch and flash counter
`define CLK_FREQ_HZ          25000000
`define TICK_TIME_US         1000
`define MS_W                 11
`define STRETCH_MS_1         11'd21
`define STRETCH_MS_2         11'd42
`define STRETCH_MS_3         11'd84
`define STRETCH_MS_4         11'd170
`define STRETCH_MS_5         11'd340
`define STRETCH_MS_6         11'd670
`define STRETCH_MS_7         11'd1300
`define FLASH_MS_0           11'd42
`define FLASH_MS_1           11'd84
`define FLASH_MS_2           11'd170
`define FLASH_MS_3           11'd340
`define FLASH_MS_4           11'd670

`endif

// >>> event_stretch.v
// pulse stretcher for one traffic or fault event
// assumes a one-cycle millisecond tick from the parent and synchronous inputs
`timescale 1ns/1ps
`include "indicator_defines.vh"

module event_stretch #(
  parameter MS_W = `MS_W
) (
  input  wire            clk,
  input  wire            nrst,
  input  wire            clr,
  input  wire            event_in,
  input  wire            tick,
  input  wire [MS_W-1:0] len,
  output wire            stretched
);

  reg [MS_W-1:0] remain_q;
  reg [MS_W-1:0] remain_d;

  // a fresh event reloads the hold time; a zero length gives a plain pass-through
  always @* begin
    remain_d = remain_q;
    if (clr) begin
      remain_d = {MS_W{1'b0}};
    end else if (event_in) begin
      remain_d = len;
    end else if (tick && (remain_q != {MS_W{1'b0}})) begin
      remain_d = remain_q - {{(MS_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      remain_q <= {MS_W{1'b0}};
    end else begin
      remain_q <= remain_d;
    end
  end

  // the hold starts at a random tick phase, so the true hold is len-1 to len ms
  assign stretched = event_in | (remain_q != {MS_W{1'b0}});

endmodule

// >>> indicator_lane.v
// source selection, override and polarity for one indicator output
// assumes stretched events and a flash phase from the parent; purely combinational
`timescale 1ns/1ps
`include "indicator_defines.vh"

module indicator_lane #(
  parameter FULL_SET = 1
) (
  input  wire [3:0] src_sel,
  input  wire [2:0] rate_qual,
  input  wire [1:0] override,
  input  wire       polarity,
  input  wire       link,
  input  wire       speed_100,
  input  wire       duplex,
  input  wire       col_s,
  input  wire       err_s,
  input  wire       tx_s,
  input  wire       rx_s,
  input  wire       act_s,
  input  wire       flash,
  output reg        pin_level
);

  reg speed_on;
  reg src_on;
  reg lamp_on;

  always @* begin
    speed_on = link & (((rate_qual == `QUAL_10BASE_T) & ~speed_100) |
                       ((rate_qual == `QUAL_100BASE_X) & speed_100));
    case (src_sel)
      `SRC_COLLISION:  src_on = col_s;
      `SRC_ERROR:      src_on = err_s;
      `SRC_DUPLEX:     src_on = duplex;
      `SRC_DUPLEX_COL: src_on = duplex | col_s;
      `SRC_SPEED:      src_on = speed_on;
      `SRC_LINK:       src_on = link;
      `SRC_TX:         src_on = tx_s;
      `SRC_RX:         src_on = rx_s;
      // output zero does not offer these two codes and leaves the lamp dark
      `SRC_ACTIVITY:   src_on = (FULL_SET != 0) & act_s;
      `SRC_LINK_RX:    src_on = (FULL_SET != 0) & (link | rx_s);
      `SRC_LINK_ACT:   src_on = link | act_s;
      `SRC_ACT_FLASH:  src_on = act_s & flash;
      `SRC_TX_FLASH:   src_on = tx_s & flash;
      `SRC_RX_FLASH:   src_on = rx_s & flash;
      `SRC_INACTIVE:   src_on = 1'b0;
      default:         src_on = 1'b0;
    endcase
    case (override)
      `OVR_NORMAL: lamp_on = src_on;
      `OVR_FLASH:  lamp_on = flash;
      `OVR_OFF:    lamp_on = 1'b0;
      `OVR_ON:     lamp_on = 1'b1;
      default:     lamp_on = src_on;
    endcase
    // polarity is applied last: 0 drives a lit lamp low, 1 drives it high
    pin_level = polarity ? lamp_on : ~lamp_on;
  end

endmodule

// >>> indicator_ctrl.v
// indicator control: registers, millisecond tick, flash timer, event stretchers
// and three output lanes with registered pins
// assumes all status inputs are synchronous to CLK_SYS and a plain register port
`timescale 1ns/1ps
`include "indicator_defines.vh"

// What this block does
// - output one follows its full source set
// - output zero lacks activity and link-receive codes
// - all-ones select keeps output inactive
// - blink codes flash output during traffic
// - global stretch time lengthens each event
// - global flash period, five valid codes
// - rate qualifier picks ten or hundred link
// - polarity bit sets active pin level
// - override forces normal, flash, off, on
module indicator_ctrl #(
  parameter CLK_FREQ_HZ = `CLK_FREQ_HZ,
  parameter TICK_TIME_US = `TICK_TIME_US,
  parameter TICK_CYCLES = (CLK_FREQ_HZ / 1000000) * TICK_TIME_US,
  parameter TICK_W = 16
) (
  input  wire              CLK_SYS,
  input  wire              NRST,
  input  wire              SOFT_RST,
  input  wire              LINK_UP,
  input  wire              SPEED_100,
  input  wire              FULL_DUPLEX,
  input  wire              COLLISION,
  input  wire              RX_ERROR,
  input  wire              TX_ACTIVE,
  input  wire              RX_ACTIVE,
  input  wire [`ADDR_W-1:0] ADDR,
  input  wire [`DATA_W-1:0] WR_DATA,
  input  wire              WR_EN,
  input  wire              RD_EN,
  output reg  [`DATA_W-1:0] RD_DATA,
  output reg               INDICATOR_OUT_ZERO,
  output reg               INDICATOR_OUT_ONE,
  output reg               INDICATOR_OUT_TWO
);

  localparam integer      TICK_LAST_I = TICK_CYCLES - 1;
  localparam [TICK_W-1:0] TICK_LAST   = TICK_LAST_I[TICK_W-1:0];
  localparam [`MS_W-1:0]  MS_ONE      = {{(`MS_W-1){1'b0}}, 1'b1};

  // configuration registers
  reg  [`DATA_W-1:0] source_select_q;
  reg  [`DATA_W-1:0] timing_speed_q;
  reg  [`DATA_W-1:0] override_pol_q;
  reg  [`DATA_W-1:0] rd_data_d;

  // timing state
  reg  [TICK_W-1:0]  tick_cnt_q;
  reg                tick_q;
  reg  [`MS_W-1:0]   flash_ms_q;
  reg                flash_q;

  // field views
  wire [2:0]         pulse_extend_sel;
  wire [2:0]         flash_period_sel;
  wire [2:0]         out_zero_rate_qual;
  wire [2:0]         out_one_rate_qual;
  wire [2:0]         out_two_rate_qual;
  wire               out_zero_polarity;
  wire               out_one_polarity;
  wire               out_two_polarity;
  wire [1:0]         out_zero_override;
  wire [1:0]         out_one_override;
  wire [1:0]         out_two_override;
  wire [3:0]         zero_src;
  wire [3:0]         one_src;
  wire [3:0]         two_src;

  // lane wiring
  wire [`MS_W-1:0]   stretch_len;
  wire [`MS_W-1:0]   flash_len;
  wire               collision_source;
  wire               error_s;
  wire               tx_s;
  wire               rx_s;
  wire               activity_source;
  wire               level_zero;
  wire               level_one;
  wire               level_two;

  assign pulse_extend_sel   = timing_speed_q[`TS_STRETCH_LSB +: 3];
  assign flash_period_sel   = timing_speed_q[`TS_FLASH_LSB +: 3];
  assign out_zero_rate_qual = timing_speed_q[`TS_QUAL_ZERO_LSB +: 3];
  assign out_one_rate_qual  = timing_speed_q[`TS_QUAL_ONE_LSB +: 3];
  assign out_two_rate_qual  = timing_speed_q[`TS_QUAL_TWO_LSB +: 3];
  assign out_zero_polarity  = override_pol_q[`OP_POL_ZERO_BIT];
  assign out_one_polarity   = override_pol_q[`OP_POL_ONE_BIT];
  assign out_two_polarity   = override_pol_q[`OP_POL_TWO_BIT];
  assign out_zero_override  = override_pol_q[`OP_OVR_ZERO_LSB +: 2];
  assign out_one_override   = override_pol_q[`OP_OVR_ONE_LSB +: 2];
  assign out_two_override   = override_pol_q[`OP_OVR_TWO_LSB +: 2];
  assign zero_src           = source_select_q[`SRC_ZERO_LSB +: 4];
  assign one_src            = source_select_q[`SRC_ONE_LSB +: 4];
  assign two_src            = source_select_q[`SRC_TWO_LSB +: 4];

  // stretch hold in milliseconds; the lower edge of each range is used
  function [`MS_W-1:0] stretch_ms;
    input [2:0] code;
    begin
      case (code)
        3'h0:    stretch_ms = {`MS_W{1'b0}};
        3'h1:    stretch_ms = `STRETCH_MS_1;
        3'h2:    stretch_ms = `STRETCH_MS_2;
        3'h3:    stretch_ms = `STRETCH_MS_3;
        3'h4:    stretch_ms = `STRETCH_MS_4;
        3'h5:    stretch_ms = `STRETCH_MS_5;
        3'h6:    stretch_ms = `STRETCH_MS_6;
        3'h7:    stretch_ms = `STRETCH_MS_7;
        default: stretch_ms = {`MS_W{1'b0}};
      endcase
    end
  endfunction

  // reserved flash codes fall back to the slowest period rather than stopping
  function [`MS_W-1:0] flash_ms;
    input [2:0] code;
    begin
      case (code)
        3'h0:    flash_ms = `FLASH_MS_0;
        3'h1:    flash_ms = `FLASH_MS_1;
        3'h2:    flash_ms = `FLASH_MS_2;
        3'h3:    flash_ms = `FLASH_MS_3;
        3'h4:    flash_ms = `FLASH_MS_4;
        default: flash_ms = `FLASH_MS_4;
      endcase
    end
  endfunction

  assign stretch_len = stretch_ms(pulse_extend_sel);
  assign flash_len   = flash_ms(flash_period_sel);

  // register writes: only a hard reset restores the defaults
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      source_select_q <= `SRC_RESET;
      timing_speed_q  <= `TS_RESET;
      override_pol_q  <= `OP_RESET;
    end else if (WR_EN) begin
      if (ADDR == `OFS_SOURCE_SELECT) begin
        source_select_q <= WR_DATA;
      end
      if (ADDR == `OFS_TIMING_SPEED) begin
        // the top bit is fixed at zero
        timing_speed_q <= WR_DATA & `TS_WRITE_MASK;
      end
      if (ADDR == `OFS_OVERRIDE_POL) begin
        override_pol_q <= WR_DATA;
      end
    end
  end

  // read data stands only in the cycle after the read strobe
  always @* begin
    rd_data_d = {`DATA_W{1'b0}};
    if (RD_EN) begin
      case (ADDR)
        `OFS_SOURCE_SELECT: rd_data_d = source_select_q;
        `OFS_TIMING_SPEED:  rd_data_d = timing_speed_q;
        `OFS_OVERRIDE_POL:  rd_data_d = override_pol_q;
        default:            rd_data_d = {`DATA_W{1'b0}};
      endcase
    end
  end

  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      RD_DATA <= {`DATA_W{1'b0}};
    end else begin
      RD_DATA <= rd_data_d;
    end
  end

  // millisecond tick; a soft reset restarts it with the rest of the timing state
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      tick_cnt_q <= {TICK_W{1'b0}};
      tick_q     <= 1'b0;
    end else if (SOFT_RST) begin
      tick_cnt_q <= {TICK_W{1'b0}};
      tick_q     <= 1'b0;
    end else if (tick_cnt_q >= TICK_LAST) begin
      tick_cnt_q <= {TICK_W{1'b0}};
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + {{(TICK_W-1){1'b0}}, 1'b1};
      tick_q     <= 1'b0;
    end
  end

  // flash phase toggles once per selected period; >= copes with a period
  // shortened while the counter is already past the new end
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      flash_ms_q <= {`MS_W{1'b0}};
      flash_q    <= 1'b0;
    end else if (SOFT_RST) begin
      flash_ms_q <= {`MS_W{1'b0}};
      flash_q    <= 1'b0;
    end else if (tick_q) begin
      if (flash_ms_q >= (flash_len - MS_ONE)) begin
        flash_ms_q <= {`MS_W{1'b0}};
        flash_q    <= ~flash_q;
      end else begin
        flash_ms_q <= flash_ms_q + MS_ONE;
      end
    end
  end

  event_stretch #(.MS_W(`MS_W)) stretch_col (
    .clk       (CLK_SYS),
    .nrst      (NRST),
    .clr       (SOFT_RST),
    .event_in  (COLLISION),
    .tick      (tick_q),
    .len       (stretch_len),
    .stretched (collision_source)
  );

  event_stretch #(.MS_W(`MS_W)) stretch_err (
    .clk       (CLK_SYS),
    .nrst      (NRST),
    .clr       (SOFT_RST),
    .event_in  (RX_ERROR),
    .tick      (tick_q),
    .len       (stretch_len),
    .stretched (error_s)
  );

  event_stretch #(.MS_W(`MS_W)) stretch_tx (
    .clk       (CLK_SYS),
    .nrst      (NRST),
    .clr       (SOFT_RST),
    .event_in  (TX_ACTIVE),
    .tick      (tick_q),
    .len       (stretch_len),
    .stretched (tx_s)
  );

  event_stretch #(.MS_W(`MS_W)) stretch_rx (
    .clk       (CLK_SYS),
    .nrst      (NRST),
    .clr       (SOFT_RST),
    .event_in  (RX_ACTIVE),
    .tick      (tick_q),
    .len       (stretch_len),
    .stretched (rx_s)
  );

  event_stretch #(.MS_W(`MS_W)) stretch_act (
    .clk       (CLK_SYS),
    .nrst      (NRST),
    .clr       (SOFT_RST),
    .event_in  (TX_ACTIVE | RX_ACTIVE),
    .tick      (tick_q),
    .len       (stretch_len),
    .stretched (activity_source)
  );

  indicator_lane #(.FULL_SET(0)) lane_zero (
    .src_sel   (zero_src),
    .rate_qual (out_zero_rate_qual),
    .override  (out_zero_override),
    .polarity  (out_zero_polarity),
    .link      (LINK_UP),
    .speed_100 (SPEED_100),
    .duplex    (FULL_DUPLEX),
    .col_s     (collision_source),
    .err_s     (error_s),
    .tx_s      (tx_s),
    .rx_s      (rx_s),
    .act_s     (activity_source),
    .flash     (flash_q),
    .pin_level (level_zero)
  );

  indicator_lane #(.FULL_SET(1)) lane_one (
    .src_sel   (one_src),
    .rate_qual (out_one_rate_qual),
    .override  (out_one_override),
    .polarity  (out_one_polarity),
    .link      (LINK_UP),
    .speed_100 (SPEED_100),
    .duplex    (FULL_DUPLEX),
    .col_s     (collision_source),
    .err_s     (error_s),
    .tx_s      (tx_s),
    .rx_s      (rx_s),
    .act_s     (activity_source),
    .flash     (flash_q),
    .pin_level (level_one)
  );

  indicator_lane #(.FULL_SET(1)) lane_two (
    .src_sel   (two_src),
    .rate_qual (out_two_rate_qual),
    .override  (out_two_override),
    .polarity  (out_two_polarity),
    .link      (LINK_UP),
    .speed_100 (SPEED_100),
    .duplex    (FULL_DUPLEX),
    .col_s     (collision_source),
    .err_s     (error_s),
    .tx_s      (tx_s),
    .rx_s      (rx_s),
    .act_s     (activity_source),
    .flash     (flash_q),
    .pin_level (level_two)
  );

  // pins come from flops; after hard reset all lamps are dark and active low
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      INDICATOR_OUT_ZERO <= 1'b1;
      INDICATOR_OUT_ONE  <= 1'b1;
      INDICATOR_OUT_TWO  <= 1'b1;
    end else begin
      INDICATOR_OUT_ZERO <= level_zero;
      INDICATOR_OUT_ONE  <= level_one;
      INDICATOR_OUT_TWO  <= level_two;
    end
  end

endmodule

// >>> indicator_lamps.sv
// lamp board model: one lamp on each of the three indicator pins
// assumes the board wiring tells which pin level lights each lamp
`timescale 1ns/1ps
module indicator_lamps (
  input  wire       pin_zero,
  input  wire       pin_one,
  input  wire       pin_two,
  input  wire [2:0] lit_high,
  output wire [2:0] lit
);
  // no latching: an unknown pin gives an unknown lamp, so the bench cannot miss it
  assign lit = ~({pin_two, pin_one, pin_zero} ^ lit_high);
endmodule

// >>> indicator_ctrl_checker.sv
// assertions on the indicator control ports: read slot and pin levels
// assumes a shadow of the three config registers kept from the write strobes
`timescale 1ns/1ps
`include "indicator_defines.vh"
module indicator_ctrl_checker (
  input wire               CLK_SYS,
  input wire               NRST,
  input wire               LINK_UP,
  input wire               SPEED_100,
  input wire [`ADDR_W-1:0] ADDR,
  input wire [`DATA_W-1:0] WR_DATA,
  input wire               WR_EN,
  input wire               RD_EN,
  input wire [`DATA_W-1:0] RD_DATA,
  input wire               INDICATOR_OUT_ZERO,
  input wire               INDICATOR_OUT_ONE,
  input wire               INDICATOR_OUT_TWO
);
  logic [15:0] sel_q;
  logic [15:0] ts_q;
  logic [15:0] op_q;
  wire  [1:0]  ovr_zero = op_q[1:0];
  wire  [1:0]  ovr_one = op_q[3:2];
  wire  [1:0]  ovr_two = op_q[5:4];
  wire         pol_zero = op_q[12];
  wire         pol_one = op_q[13];
  wire         pol_two = op_q[14];
  wire  [2:0]  qual_zero = ts_q[2:0];
  wire         speed_lit = LINK_UP & ((qual_zero == `QUAL_100BASE_X) ? SPEED_100 :
                           (qual_zero == `QUAL_10BASE_T) ? ~SPEED_100 : 1'b0);
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      sel_q <= `SRC_RESET;
      ts_q <= `TS_RESET;
      op_q <= `OP_RESET;
    end else if (WR_EN) begin
      if (ADDR == `OFS_SOURCE_SELECT) sel_q <= WR_DATA;
      if (ADDR == `OFS_TIMING_SPEED) ts_q <= WR_DATA & `TS_WRITE_MASK;
      if (ADDR == `OFS_OVERRIDE_POL) op_q <= WR_DATA;
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  property p_rd_idle; !$past(RD_EN) |-> RD_DATA == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_rd_fixed; RD_EN && ADDR == `OFS_TIMING_SPEED |=> RD_DATA[15] == 1'b0; endproperty
  a_rd_fixed: assert property (p_rd_fixed) else $error("fixed bit reads one");
  property p_rd_op; RD_EN && !WR_EN && ADDR == `OFS_OVERRIDE_POL |=> RD_DATA == $past(op_q);
  endproperty
  a_rd_op: assert property (p_rd_op) else $error("override register readback wrong");
  property p_force_on; ovr_zero == `OVR_ON |=> INDICATOR_OUT_ZERO == $past(pol_zero); endproperty
  a_force_on: assert property (p_force_on) else $error("forced-on lamp not lit");
  property p_force_off; ovr_one == `OVR_OFF |=> INDICATOR_OUT_ONE != $past(pol_one); endproperty
  a_force_off: assert property (p_force_off) else $error("forced-off lamp lit");
  property p_inactive;
    sel_q[11:8] == `SRC_INACTIVE && ovr_two == `OVR_NORMAL |=> INDICATOR_OUT_TWO != $past(pol_two);
  endproperty
  a_inactive: assert property (p_inactive) else $error("inactive code lights lamp");
  property p_link;
    sel_q[7:4] == `SRC_LINK && ovr_one == `OVR_NORMAL
      |=> INDICATOR_OUT_ONE == ($past(LINK_UP) ~^ $past(pol_one));
  endproperty
  a_link: assert property (p_link) else $error("link source level wrong");
  property p_unoffered;
    (sel_q[3:0] == `SRC_ACTIVITY || sel_q[3:0] == `SRC_LINK_RX) && ovr_zero == `OVR_NORMAL
      |=> INDICATOR_OUT_ZERO != $past(pol_zero);
  endproperty
  a_unoffered: assert property (p_unoffered) else $error("unoffered code lights lamp");
  property p_speed;
    sel_q[3:0] == `SRC_SPEED && ovr_zero == `OVR_NORMAL
      |=> INDICATOR_OUT_ZERO == ($past(speed_lit) ~^ $past(pol_zero));
  endproperty
  a_speed: assert property (p_speed) else $error("speed source level wrong");
endmodule
bind indicator_ctrl indicator_ctrl_checker indicator_ctrl_checker_i (.CLK_SYS, .NRST,
  .LINK_UP, .SPEED_100, .ADDR, .WR_DATA, .WR_EN, .RD_EN, .RD_DATA, .INDICATOR_OUT_ZERO,
  .INDICATOR_OUT_ONE, .INDICATOR_OUT_TWO);

// >>> tb_indicator_ctrl.sv
// self-checking bench for indicator_ctrl with a lamp board on the pins
// assumes a 4-cycle millisecond tick so every ms figure is four clocks
`timescale 1ns/1ps
`include "indicator_defines.vh"
module tb_indicator_ctrl;
  logic               clk_sys = 1'b0;
  logic               nrst = 1'b0;
  logic               soft_rst = 1'b0;
  logic               link_up = 1'b0;
  logic               speed_100 = 1'b0;
  logic               full_duplex = 1'b0;
  logic [3:0]         events = 4'h0;
  logic               wr_en = 1'b0;
  logic               rd_en = 1'b0;
  logic [`ADDR_W-1:0] addr = 5'h00;
  logic [15:0]        wr_data = 16'h0000;
  logic [2:0]         lit_high = 3'h0;
  wire  [15:0]        rd_data;
  wire                out_zero;
  wire                out_one;
  wire                out_two;
  wire  [2:0]         lit;
  int                 num_errors = 0;
  int                 samples_checked = 0;
  always #20 clk_sys = ~clk_sys;
  indicator_ctrl #(.TICK_CYCLES(4)) indicator_ctrl_i (.CLK_SYS(clk_sys), .NRST(nrst),
    .SOFT_RST(soft_rst), .LINK_UP(link_up), .SPEED_100(speed_100), .FULL_DUPLEX(full_duplex),
    .COLLISION(events[0]), .RX_ERROR(events[1]), .TX_ACTIVE(events[2]), .RX_ACTIVE(events[3]),
    .ADDR(addr), .WR_DATA(wr_data), .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data),
    .INDICATOR_OUT_ZERO(out_zero), .INDICATOR_OUT_ONE(out_one), .INDICATOR_OUT_TWO(out_two));
  indicator_lamps indicator_lamps_i (.pin_zero(out_zero), .pin_one(out_one),
    .pin_two(out_two), .lit_high(lit_high), .lit(lit));
  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_lit(input logic [2:0] exp);
    samples_checked++;
    if (lit !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t lamps=%h exp=%h", $time, lit, exp);
    end
  endtask
  // every access leaves one idle cycle so no strobe is assigned twice in a step
  task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic check_rd(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 d = rd_data;
    check16(d, exp);
    @(posedge clk_sys);
  endtask
  task automatic settle_lit(input logic [2:0] exp);
    repeat (2) @(posedge clk_sys);
    #1 check_lit(exp);
    @(posedge clk_sys);
  endtask
  task automatic t_reset;
    check_rd(`OFS_SOURCE_SELECT, 16'h4A44);
    check_rd(`OFS_TIMING_SPEED, 16'h4205);
    check_rd(`OFS_OVERRIDE_POL, 16'h0000);
    check_rd(5'h00, 16'h0000);
    settle_lit(3'b000);
    $display("reset values done");
  endtask
  task automatic t_regs;
    reg_wr(`OFS_TIMING_SPEED, 16'hFFFF);
    check_rd(`OFS_TIMING_SPEED, 16'h7FFF);
    reg_wr(`OFS_OVERRIDE_POL, 16'h8FC0);
    reg_wr(5'h03, 16'h1234);
    check_rd(`OFS_SOURCE_SELECT, 16'h4A44);
    soft_rst <= 1'b1;
    @(posedge clk_sys);
    soft_rst <= 1'b0;
    check_rd(`OFS_OVERRIDE_POL, 16'h8FC0);
    check_rd(`OFS_TIMING_SPEED, 16'h7FFF);
    reg_wr(`OFS_TIMING_SPEED, 16'h4205);
    reg_wr(`OFS_OVERRIDE_POL, 16'h0000);
    $display("register access done");
  endtask
  task automatic t_override;
    logic [1:0] o;
    for (int p = 0; p < 2; p++) begin
      for (int k = 2; k < 4; k++) begin
        o = k[1:0];
        lit_high <= {3{p[0]}};
        reg_wr(`OFS_OVERRIDE_POL, {1'b0, {3{p[0]}}, 6'h00, o, o, o});
        settle_lit({3{o[0]}});
      end
    end
    lit_high <= 3'h0;
    reg_wr(`OFS_OVERRIDE_POL, 16'h0000);
    $display("override and polarity done");
  endtask
  // blink codes are left out here; t_flash judges the phase of the transmit blink code only
  task automatic run_set(input logic [15:0] e1, input logic [15:0] e0);
    logic [3:0] c;
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      if (c < 4'hB || c > 4'hD) begin
        reg_wr(`OFS_SOURCE_SELECT, {4'h4, c, c, c});
        settle_lit({e1[c], e1[c], e0[c]});
      end
    end
  endtask
  task automatic t_sources;
    link_up <= 1'b1;
    run_set(16'h0630, 16'h0420);
    link_up <= 1'b0;
    full_duplex <= 1'b1;
    events <= 4'hF;
    run_set(16'h07CF, 16'h04CF);
    events <= 4'h0;
    reg_wr(`OFS_SOURCE_SELECT, 16'h4A64);
    repeat (800) @(posedge clk_sys);
    $display("source codes done");
  endtask
  task automatic pulse_len(output int n);
    events <= 4'h4;
    @(posedge clk_sys);
    events <= 4'h0;
    n = 0;
    // the first sample must see the cycle the event itself lights the lamp
    repeat (120) begin
      #1 if (lit[1] === 1'b1) n++;
      @(posedge clk_sys);
    end
    @(posedge clk_sys);
  endtask
  task automatic t_stretch;
    int n;
    reg_wr(`OFS_TIMING_SPEED, 16'h1205);
    pulse_len(n);
    check16({15'h0000, n >= 80 && n <= 88}, 16'h0001);
    reg_wr(`OFS_TIMING_SPEED, 16'h0205);
    pulse_len(n);
    check16(n[15:0], 16'h0001);
    $display("pulse stretch done");
  endtask
  task automatic wait_toggle(output int n);
    logic p;
    p = out_zero;
    n = 0;
    while (out_zero === p && n < 6000) begin
      @(posedge clk_sys);
      #1 n++;
    end
  endtask
  task automatic t_flash;
    int n;
    int per [5] = '{42, 84, 170, 340, 670};
    reg_wr(`OFS_OVERRIDE_POL, 16'h0001);
    reg_wr(`OFS_SOURCE_SELECT, 16'h4AC4);
    events <= 4'h4;
    for (int f = 0; f < 5; f++) begin
      reg_wr(`OFS_TIMING_SPEED, {4'h0, f[2:0], 9'h005});
      wait_toggle(n);
      wait_toggle(n);
      check16(n[15:0], 16'(per[f] * 4));
      check16({15'h0000, lit[1]}, {15'h0000, lit[0]});
      @(posedge clk_sys);
    end
    events <= 4'h0;
    reg_wr(`OFS_OVERRIDE_POL, 16'h0000);
    $display("flash period done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    t_reset;
    t_regs;
    t_override;
    t_sources;
    t_stretch;
    t_flash;
    tally_and_finish;
  end
  // about 12000 cycles are expected; this is well over twice that
  initial begin
    #3000000;
    num_errors++;
    tally_and_finish;
  end
endmodule
